// >>> bench/codec_core_model.sv
// Behavioural coding cores on the far side of the homing block
module codec_core_model (
  // Clock
  input  wire logic                 core_clk_i,
  // Encoder core: samples in, parameters out
  input  wire logic                 smp_valid_i,
  input  wire homing_pkg::word_type smp_i,
  output logic                      prm_valid_o = 0,
  output homing_pkg::word_type      prm_o = '0,
  // Decoder core: parameters in, samples out
  input  wire logic                 prm_valid_i,
  input  wire homing_pkg::word_type prm_i,
  output logic                      smp_valid_o = 0,
  output homing_pkg::word_type      smp_o = '0
);
  timeunit 1ns;
  timeprecision 1ns;
  int   n_smp = 0;
  int   n_prm = 0;
  event enc_go;
  event dec_go;

  // Counted from sof, so a restart mid-frame realigns
  always @(posedge core_clk_i) begin
    if (smp_valid_i === 1) n_smp = smp_i.sof ? 1 : n_smp + 1;
    if (prm_valid_i === 1) n_prm = prm_i.sof ? 1 : n_prm + 1;
    if (smp_valid_i === 1 && n_smp == 160) -> enc_go;
    if (prm_valid_i === 1 && n_prm == 57) -> dec_go;
  end

  // Answer delay varies; released lines are inverted so stale data cannot pass
  initial forever begin
    @(enc_go);
    repeat (1 + $urandom_range(6)) @(posedge core_clk_i);
    for (int i = 0; i < 57; i++) begin
      prm_valid_o <= 1;
      prm_o       <= '{sof: i == 0, data: 16'hA5A5 ^ 16'(i)};
      @(posedge core_clk_i);
    end
    prm_valid_o <= 0;
    prm_o       <= ~prm_o;
  end

  initial forever begin
    @(dec_go);
    repeat (1 + $urandom_range(6)) @(posedge core_clk_i);
    for (int i = 0; i < 160; i++) begin
      smp_valid_o <= 1;
      smp_o       <= '{sof: i == 0, data: 16'h5A5A ^ 16'(i)};
      @(posedge core_clk_i);
    end
    smp_valid_o <= 0;
    smp_o       <= ~smp_o;
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the codec homing controller
`include "homing_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 core_clk_i = 0, rst_i = 1, cyc = 0, stb = 0, wbwe = 0, esv = 0, dpv = 0;
  logic                 ack, ecsv, ecpv, epv, eh, eah, dcpv, dcsv, dsv, dh, deh, dah;
  logic [11:0]          adr = '0;
  logic [31:0]          wdat = '0, rdat, rd;
  homing_pkg::word_type es = '0, dp = '0, ecs, ecp, ep, dcp, dcs, ds;
  int                   n_errors = 0, check_count = 0, enc_home = 1, dec_home = 1;
  int                   n_eh = 0, n_dh = 0, n_ehp = 0, n_dhp = 0, n_early = 0;
  logic [15:0]          eq[$], dq[$];
  logic                 stwe = 0;
  homing_pkg::st_wr_type stw = '0;

  speech_codec_homing speech_codec_homing_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wbwe),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .enc_smp_valid_i(esv), .enc_smp_i(es), .enc_core_smp_valid_o(ecsv), .enc_core_smp_o(ecs),
    .enc_core_prm_valid_i(ecpv), .enc_core_prm_i(ecp), .enc_prm_valid_o(epv), .enc_prm_o(ep),
    .enc_core_home_o(eh), .enc_at_home_o(eah), .dec_prm_valid_i(dpv), .dec_prm_i(dp),
    .dec_core_prm_valid_o(dcpv), .dec_core_prm_o(dcp), .dec_core_smp_valid_i(dcsv),
    .dec_core_smp_i(dcs), .dec_smp_valid_o(dsv), .dec_smp_o(ds), .dec_core_home_o(dh),
    .dec_early_home_o(deh), .dec_at_home_o(dah), .st_we_i(stwe), .st_wr_i(stw));

  codec_core_model codec_core_model_inst (
    .core_clk_i(core_clk_i), .smp_valid_i(ecsv), .smp_i(ecs), .prm_valid_i(dcpv), .prm_i(dcp),
    .prm_valid_o(ecpv), .prm_o(ecp), .smp_valid_o(dcsv), .smp_o(dcs));

  initial forever #25 core_clk_i = ~core_clk_i;

  function automatic logic [15:0] dhf(input int i);
    logic [911:0] f;
    f = `DHF_FRAME;
    return f[911 - 16 * i -: 16];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Classic cycle; values seen after the edge are the ones sampled at it
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int t;
    cyc  <= 1;
    stb  <= 1;
    wbwe <= we;
    adr  <= a;
    wdat <= d;
    t = 0;
    do begin @(posedge core_clk_i); t++; end while (ack !== 1 && t < 20);
    if (ack !== 1) n_errors++;
    rd = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge core_clk_i);
  endtask

  task automatic settle(input int q_left);
    chk(q_left, 0);
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic enc_frame(input bit homing);
    for (int i = 0; i < 57; i++) eq.push_back(homing && enc_home ? dhf(i) : 16'hA5A5 ^ 16'(i));
    for (int i = 0; i < 160; i++) begin
      esv <= 1;
      es  <= '{sof: i == 0, data: homing ? 16'h0008 : 16'($urandom) | 16'h8000};
      @(posedge core_clk_i);
    end
    esv     <= 0;
    es.data <= ~es.data;
    for (int t = 0; t < 400 && eq.size() > 0; t++) @(posedge core_clk_i);
    settle(eq.size());
    enc_home = homing;
    n_eh += homing;
    chk(eah, enc_home);
    chk(n_ehp, n_eh);
  endtask

  task automatic dec_frame(input bit homing);
    for (int i = 0; i < 160; i++) dq.push_back(homing && dec_home ? 16'h0008 : 16'h5A5A ^ 16'(i));
    for (int i = 0; i < 57; i++) begin
      dpv <= 1;
      dp  <= '{sof: i == 0, data: homing || i > 0 ? dhf(i) : 16'($urandom) | 16'h1000};
      @(posedge core_clk_i);
    end
    dpv     <= 0;
    dp.data <= ~dp.data;
    for (int t = 0; t < 400 && dq.size() > 0; t++) @(posedge core_clk_i);
    settle(dq.size());
    dec_home = homing;
    n_dh += homing;
    chk(dah, dec_home);
    chk(n_dhp, n_dh);
  endtask

  always @(posedge core_clk_i) begin
    if (epv === 1) chk(ep.data, eq.size() ? eq.pop_front() : 16'hDEAD);
    if (dsv === 1) chk(ds.data, dq.size() ? dq.pop_front() : 16'hDEAD);
    n_ehp += (eh === 1);
    n_dhp += (dh === 1);
    n_early += (deh === 1);
  end

  initial begin
    #2_000_000;
    n_errors++;
    summarize;
  end

  initial begin
    void'($urandom(16427));
    repeat (5) @(posedge core_clk_i);
    rst_i <= 0;
    @(posedge core_clk_i);
    wb(0, `REG_CTRL, 0); chk(rd, 32'h0000_0004);
    wb(0, `REG_STATUS, 0); chk(rd, 32'h0000_0003);
    wb(0, `REG_ST_BASE, 0); chk(rd, 32'h0000_7530);
    wb(0, `REG_ST_BASE + 12'h024, 0); chk(rd, 32'h0000_9A70);
    wb(0, `REG_ST_BASE + 12'h090, 0); chk(rd, 32'h0000_1000);
    wb(0, `REG_ST_BASE + 12'h094, 0); chk(rd, 32'h0000_F6B3);
    wb(0, 12'h0FC, 0); chk(rd, 32'h0000_0000);
    // Core drifts two held words away from home so homing has work to do
    stwe <= 1;
    stw  <= '{addr: 6'h00, data: 16'h1234};
    @(posedge core_clk_i);
    stw  <= '{addr: 6'h24, data: 16'h4321};
    @(posedge core_clk_i);
    stwe <= 0;
    wb(0, `REG_ST_BASE, 0); chk(rd, 32'h0000_1234);
    wb(0, `REG_ST_BASE + 12'h090, 0); chk(rd, 32'h0000_4321);
    enc_frame(1); enc_frame(1); enc_frame(0); enc_frame(1); enc_frame(1);
    wb(0, `REG_ENC_CNT, 0); chk(rd, 32'h0000_0004);
    wb(0, `REG_ST_BASE, 0); chk(rd, 32'h0000_7530);
    wb(1, `REG_ENC_CNT, 0);
    wb(0, `REG_ENC_CNT, 0); chk(rd, 32'h0000_0000);
    dec_frame(1); dec_frame(1); dec_frame(0); dec_frame(1); dec_frame(1);
    wb(0, `REG_DEC_CNT, 0); chk(rd, 32'h0000_0004);
    wb(0, `REG_ST_BASE + 12'h090, 0); chk(rd, 32'h0000_1000);
    chk(n_early > 0, 1);
    summarize;
  end
endmodule

// >>> design/dec_homing_detect.sv
// Detector for the decoder homing frame on the parameter stream
`include "homing_consts.svh"
module dec_homing_detect (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // Parameter stream
  input  wire logic               prm_valid_i,
  input  wire homing_pkg::word_type prm_i,
  // Verdict
  output logic                    early_o,
  output logic                    frame_end_o,
  output logic                    homing_o
);

  logic [5:0] cnt_reg;
  logic       match_reg;
  logic       run_reg;

  wire [5:0] idx       = prm_i.sof ? 6'h00 : cnt_reg;
  wire       eq        = prm_i.data == homing_pkg::dhf_value(idx);
  wire       in_frame  = prm_i.sof | run_reg;
  wire       match_now = eq & (prm_i.sof | match_reg);
  wire       last      = prm_valid_i & in_frame & (idx == `DEC_LAST_IDX);
  wire       early_pt  = prm_valid_i & in_frame & (idx == `DEC_EARLY_IDX);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg     <= 6'h00;
      match_reg   <= 1'b0;
      run_reg     <= 1'b0;
      early_o     <= 1'b0;
      frame_end_o <= 1'b0;
      homing_o    <= 1'b0;
    end else begin
      early_o     <= early_pt & match_now;
      frame_end_o <= last;
      if (last) homing_o <= match_now;
      if (prm_valid_i) begin
        cnt_reg   <= last ? 6'h00 : idx + 6'h01;
        match_reg <= match_now;
        run_reg   <= in_frame & ~last;
      end
    end
  end

  chk_dec_param_mismatch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    prm_valid_i && in_frame && !eq |=> !match_reg) else $error("mismatching parameter kept the match");

endmodule

// >>> design/enc_homing_detect.sv
// Detector for the encoder homing frame on the sample stream
`include "homing_consts.svh"
module enc_homing_detect (
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // Sample stream
  input  wire logic               smp_valid_i,
  input  wire homing_pkg::word_type smp_i,
  // Verdict
  output logic                    frame_end_o,
  output logic                    homing_o
);

  logic [7:0] cnt_reg;
  logic       match_reg;
  logic       run_reg;

  wire [7:0] idx       = smp_i.sof ? 8'h00 : cnt_reg;
  wire       eq        = smp_i.data == `ENC_HOME_SAMPLE;
  wire       in_frame  = smp_i.sof | run_reg;
  wire       match_now = eq & (smp_i.sof | match_reg);
  // Samples before the first frame start are not aligned and never count
  wire       last      = smp_valid_i & in_frame & (idx == `ENC_LAST_IDX);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_reg     <= 8'h00;
      match_reg   <= 1'b0;
      run_reg     <= 1'b0;
      frame_end_o <= 1'b0;
      homing_o    <= 1'b0;
    end else begin
      frame_end_o <= last;
      if (last) homing_o <= match_now;
      if (smp_valid_i) begin
        cnt_reg   <= last ? 8'h00 : idx + 8'h01;
        match_reg <= match_now;
        run_reg   <= in_frame & ~last;
      end
    end
  end

  chk_enc_match_break: assert property (@(posedge core_clk_i) disable iff (rst_i)
    smp_valid_i && in_frame && !eq |=> !match_reg) else $error("non-homing sample kept the match");
  chk_enc_end_on_last: assert property (@(posedge core_clk_i) disable iff (rst_i)
    frame_end_o |-> $past(smp_valid_i) && $past(idx) == `ENC_LAST_IDX) else $error("frame end off the 160th sample");

endmodule

// >>> design/homing_consts.svh
// Constants for codec homing: frame sizes, homing patterns, home values, register map
// What this block does
// - Encoder runs a homing frame through normal coding first and emits parameters.
// - Encoder at home on a homing frame emits the decoder homing frame.
// - After an encoder homing frame all encoder state returns to home.
// - N encoder homing frames yield at least N-1 decoder homing frames.
// - Decoder produces the speech frame before any state reset.
// - Decoder at home replaces that frame's speech by the encoder homing frame.
// - After a decoder homing frame all decoder state returns to home.
// - N decoder homing frames yield at least N-1 encoder homing frames.
// - Decoder at home may detect homing from the first eighteen parameters.
// - Encoder homing zeroes histories and loads line-spectral-pair home values.
// - Encoder homing clears all high-pass pre-filter memories.
// - Decoder homing sets past gain 4096, spectral history, gain energies -2381.
// - Encoder homing frame is 160 samples of 0008 hex.
// - Decoder homing frame matches every parameter against one fixed set.
`ifndef HOMING_CONSTS_SVH
`define HOMING_CONSTS_SVH

`define ENC_LAST_IDX    8'h9F
`define ENC_HOME_SAMPLE 16'h0008
`define DEC_LAST_IDX    6'h38
`define DEC_EARLY_IDX   6'h11
`define OUT_LAST_IDX    8'h9F

// Parameter stream order: 5 spectral, then per subframe lag, pitch gain, 10 pulses, code gain
`define DHF_FRAME { \
  16'h0004, 16'h002F, 16'h00B4, 16'h0090, 16'h003E, \
  16'h0156, 16'h000B, 16'h0000, 16'h0001, 16'h000F, 16'h0001, 16'h000D, \
  16'h0000, 16'h0003, 16'h0000, 16'h0003, 16'h0000, 16'h0003, \
  16'h0036, 16'h0001, 16'h0008, 16'h0008, 16'h0005, 16'h0008, 16'h0000, \
  16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, \
  16'h0156, 16'h0000, 160'h0, 16'h0000, \
  16'h0036, 16'h000B, 160'h0, 16'h0000 }

// Entry 0 in the low word: 30000 down to -26000
`define LSP_HOME {16'h9A70, 16'hADF8, 16'hC568, 16'hE0C0, 16'h0000, \
  16'h1F40, 16'h3A98, 16'h5208, 16'h6590, 16'h7530}
`define AGC_HOME_GAIN   16'h1000
`define QUA_EN_HOME     16'hF6B3

// State bank layout
`define ST_ENC_LSPQ 6'h0A
`define ST_ENC_HP   6'h14
`define ST_DEC_LSP  6'h1A
`define ST_DEC_GAIN 6'h24
`define ST_LAST     6'h28
`define ST_DEPTH    41

// Register map
`define REG_CTRL      12'h000
`define REG_STATUS    12'h004
`define REG_ENC_CNT   12'h008
`define REG_DEC_CNT   12'h00C
`define REG_ST_BASE   12'h100
`define REG_ST_END    12'h1A0
`define CTRL_ENC_HOME 0
`define CTRL_DEC_HOME 1
`define CTRL_EARLY_EN 2

`endif

// >>> design/homing_pkg.sv
// Types and table lookups shared by the homing logic
`include "homing_consts.svh"
package homing_pkg;

  typedef struct packed {
    logic        sof;
    logic [15:0] data;
  } word_type;

  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] data;
  } st_wr_type;

  function automatic logic [15:0] dhf_value(input logic [5:0] idx);
    logic [911:0] sh;
    logic [5:0]   pos;
    pos = `DEC_LAST_IDX - idx;
    sh  = `DHF_FRAME >> {pos, 4'h0};
    return sh[15:0];
  endfunction

  function automatic logic [15:0] lsp_home(input logic [5:0] i);
    logic [159:0] sh;
    sh = `LSP_HOME >> {i, 4'h0};
    return sh[15:0];
  endfunction

  function automatic logic [15:0] home_value(input logic [5:0] a);
    logic [15:0] v;
    if (a < `ST_ENC_LSPQ) v = lsp_home(a);
    else if (a < `ST_ENC_HP) v = lsp_home(a - `ST_ENC_LSPQ);
    else if (a < `ST_DEC_LSP) v = 16'h0000;
    else if (a < `ST_DEC_GAIN) v = lsp_home(a - `ST_DEC_LSP);
    else if (a == `ST_DEC_GAIN) v = `AGC_HOME_GAIN;
    else v = `QUA_EN_HOME;
    return v;
  endfunction

endpackage

// >>> design/speech_codec_homing.sv
// Homing controller for a frame-based speech encoder and decoder, with Wishbone registers
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`include "homing_consts.svh"
module speech_codec_homing (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [11:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // Encoder: samples in, to core, parameters back, out
  input  wire logic                  enc_smp_valid_i,
  input  wire homing_pkg::word_type  enc_smp_i,
  output logic                       enc_core_smp_valid_o,
  output homing_pkg::word_type       enc_core_smp_o,
  input  wire logic                  enc_core_prm_valid_i,
  input  wire homing_pkg::word_type  enc_core_prm_i,
  output logic                       enc_prm_valid_o,
  output homing_pkg::word_type       enc_prm_o,
  output logic                       enc_core_home_o,
  output logic                       enc_at_home_o,
  // Decoder: parameters in, to core, speech back, out
  input  wire logic                  dec_prm_valid_i,
  input  wire homing_pkg::word_type  dec_prm_i,
  output logic                       dec_core_prm_valid_o,
  output homing_pkg::word_type       dec_core_prm_o,
  input  wire logic                  dec_core_smp_valid_i,
  input  wire homing_pkg::word_type  dec_core_smp_i,
  output logic                       dec_smp_valid_o,
  output homing_pkg::word_type       dec_smp_o,
  output logic                       dec_core_home_o,
  output logic                       dec_early_home_o,
  output logic                       dec_at_home_o,
  // Core write-back of held state words
  input  wire logic                  st_we_i,
  input  wire homing_pkg::st_wr_type st_wr_i
);

  // Register file and bus
  logic        wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic        early_en_reg;
  logic [15:0] enc_cnt_reg;
  logic [15:0] dec_cnt_reg;
  logic [15:0] st_mem_reg [0:`ST_DEPTH-1];

  // Encoder path
  logic                 enc_smp_valid_reg;
  homing_pkg::word_type enc_smp_reg;
  logic                 enc_frame_end;
  logic                 enc_frame_hom;
  logic                 enc_pend_hom_reg;
  logic [5:0]           enc_pidx_reg;
  logic                 enc_prm_valid_reg;
  homing_pkg::word_type enc_prm_reg;
  logic                 enc_home_reg;
  logic                 enc_at_home_reg;

  // Decoder path
  logic                 dec_prm_valid_reg;
  homing_pkg::word_type dec_prm_reg;
  logic                 dec_early;
  logic                 dec_frame_end;
  logic                 dec_frame_hom;
  logic                 dec_pend_hom_reg;
  logic [7:0]           dec_sidx_reg;
  logic                 dec_smp_valid_reg;
  homing_pkg::word_type dec_smp_reg;
  logic                 dec_home_reg;
  logic                 dec_early_reg;
  logic                 dec_at_home_reg;

  // Bus decode; writes commit on the edge where the master sees ack
  wire        wb_req     = wb_cyc_i & wb_stb_i;
  wire        wb_take    = wb_req & ~wb_ack_reg;
  wire        wb_commit  = wb_req & wb_we_i & wb_ack_reg;
  wire        sel_ctrl   = wb_adr_i == `REG_CTRL;
  wire        sel_status = wb_adr_i == `REG_STATUS;
  wire        sel_enc    = wb_adr_i == `REG_ENC_CNT;
  wire        sel_dec    = wb_adr_i == `REG_DEC_CNT;
  wire        sel_st     = (wb_adr_i >= `REG_ST_BASE) & (wb_adr_i <= `REG_ST_END) & (wb_adr_i[1:0] == 2'b00);
  wire [5:0]  st_rd_addr = wb_adr_i[7:2];
  wire        ctrl_wr    = wb_commit & sel_ctrl & wb_sel_i[0];
  wire        enc_force  = ctrl_wr & wb_dat_i[`CTRL_ENC_HOME];
  wire        dec_force  = ctrl_wr & wb_dat_i[`CTRL_DEC_HOME];
  wire        enc_clr    = wb_commit & sel_enc;
  wire        dec_clr    = wb_commit & sel_dec;
  wire [31:0] status_word = {28'h000_0000, dec_pend_hom_reg, enc_pend_hom_reg, dec_at_home_reg, enc_at_home_reg};
  wire [31:0] rd_data    = sel_ctrl   ? {29'h0000_0000, early_en_reg, 2'b00} :
                           sel_status ? status_word :
                           sel_enc    ? {16'h0000, enc_cnt_reg} :
                           sel_dec    ? {16'h0000, dec_cnt_reg} :
                           sel_st     ? {16'h0000, st_mem_reg[st_rd_addr]} : 32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wb_ack_reg   <= 1'b0;
      wb_dat_reg   <= 32'h0000_0000;
      early_en_reg <= 1'b1;
    end else begin
      wb_ack_reg <= wb_take;
      if (wb_take) wb_dat_reg <= rd_data;
      if (ctrl_wr) early_en_reg <= wb_dat_i[`CTRL_EARLY_EN];
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;

  // Encoder side
  enc_homing_detect u_enc_det (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .smp_valid_i (enc_smp_valid_i),
    .smp_i       (enc_smp_i),
    .frame_end_o (enc_frame_end),
    .homing_o    (enc_frame_hom)
  );

  wire [5:0]  enc_pidx     = enc_core_prm_i.sof ? 6'h00 : enc_pidx_reg;
  wire        enc_plast    = enc_core_prm_valid_i & (enc_pidx == `DEC_LAST_IDX);
  wire        enc_subst    = enc_pend_hom_reg & enc_at_home_reg;
  wire        enc_home_now = (enc_plast & enc_pend_hom_reg) | enc_force;
  // Substitution only pins down what a home-state core produces anyway, guarding against core drift
  wire [15:0] enc_prm_data = enc_subst ? homing_pkg::dhf_value(enc_pidx) : enc_core_prm_i.data;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      enc_smp_valid_reg <= 1'b0;
      enc_smp_reg       <= '0;
      enc_pend_hom_reg  <= 1'b0;
      enc_pidx_reg      <= 6'h00;
      enc_prm_valid_reg <= 1'b0;
      enc_prm_reg       <= '0;
      enc_home_reg      <= 1'b0;
      enc_at_home_reg   <= 1'b1;
      enc_cnt_reg       <= 16'h0000;
    end else begin
      enc_smp_valid_reg <= enc_smp_valid_i;
      if (enc_smp_valid_i) enc_smp_reg <= enc_smp_i;
      // A new verdict may land while the last parameter of the old frame leaves
      if (enc_frame_end) enc_pend_hom_reg <= enc_frame_hom;
      else if (enc_plast) enc_pend_hom_reg <= 1'b0;
      if (enc_core_prm_valid_i) enc_pidx_reg <= enc_plast ? 6'h00 : enc_pidx + 6'h01;
      enc_prm_valid_reg <= enc_core_prm_valid_i;
      if (enc_core_prm_valid_i) enc_prm_reg <= '{sof: enc_core_prm_i.sof, data: enc_prm_data};
      enc_home_reg <= enc_home_now;
      if (enc_home_now) enc_at_home_reg <= 1'b1;
      else if (enc_plast) enc_at_home_reg <= 1'b0;
      enc_cnt_reg <= (enc_clr ? 16'h0000 : enc_cnt_reg) + {15'h0000, enc_plast & enc_pend_hom_reg};
    end
  end

  assign enc_core_smp_valid_o = enc_smp_valid_reg;
  assign enc_core_smp_o       = enc_smp_reg;
  assign enc_prm_valid_o      = enc_prm_valid_reg;
  assign enc_prm_o            = enc_prm_reg;
  assign enc_core_home_o      = enc_home_reg;
  assign enc_at_home_o        = enc_at_home_reg;

  // Decoder side
  dec_homing_detect u_dec_det (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .prm_valid_i (dec_prm_valid_i),
    .prm_i       (dec_prm_i),
    .early_o     (dec_early),
    .frame_end_o (dec_frame_end),
    .homing_o    (dec_frame_hom)
  );

  wire [7:0]  dec_sidx     = dec_core_smp_i.sof ? 8'h00 : dec_sidx_reg;
  wire        dec_slast    = dec_core_smp_valid_i & (dec_sidx == `OUT_LAST_IDX);
  wire        dec_subst    = dec_pend_hom_reg & dec_at_home_reg;
  wire        dec_home_now = (dec_slast & dec_pend_hom_reg) | dec_force;
  // Early verdict relies on test sequences never opening with a near-homing frame
  wire        dec_early_ok = dec_early & dec_at_home_reg & early_en_reg;
  wire [15:0] dec_smp_data = dec_subst ? `ENC_HOME_SAMPLE : dec_core_smp_i.data;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      dec_prm_valid_reg <= 1'b0;
      dec_prm_reg       <= '0;
      dec_pend_hom_reg  <= 1'b0;
      dec_sidx_reg      <= 8'h00;
      dec_smp_valid_reg <= 1'b0;
      dec_smp_reg       <= '0;
      dec_home_reg      <= 1'b0;
      dec_early_reg     <= 1'b0;
      dec_at_home_reg   <= 1'b1;
      dec_cnt_reg       <= 16'h0000;
    end else begin
      dec_prm_valid_reg <= dec_prm_valid_i;
      if (dec_prm_valid_i) dec_prm_reg <= dec_prm_i;
      if (dec_frame_end) dec_pend_hom_reg <= dec_frame_hom | dec_pend_hom_reg & dec_early_reg;
      else if (dec_early_ok) dec_pend_hom_reg <= 1'b1;
      else if (dec_slast) dec_pend_hom_reg <= 1'b0;
      dec_early_reg <= dec_early_ok | (dec_early_reg & ~dec_frame_end);
      if (dec_core_smp_valid_i) dec_sidx_reg <= dec_slast ? 8'h00 : dec_sidx + 8'h01;
      dec_smp_valid_reg <= dec_core_smp_valid_i;
      if (dec_core_smp_valid_i) dec_smp_reg <= '{sof: dec_core_smp_i.sof, data: dec_smp_data};
      dec_home_reg <= dec_home_now;
      if (dec_home_now) dec_at_home_reg <= 1'b1;
      else if (dec_slast) dec_at_home_reg <= 1'b0;
      dec_cnt_reg <= (dec_clr ? 16'h0000 : dec_cnt_reg) + {15'h0000, dec_slast & dec_pend_hom_reg};
    end
  end

  assign dec_core_prm_valid_o = dec_prm_valid_reg;
  assign dec_core_prm_o       = dec_prm_reg;
  assign dec_smp_valid_o      = dec_smp_valid_reg;
  assign dec_smp_o            = dec_smp_reg;
  assign dec_core_home_o      = dec_home_reg;
  assign dec_early_home_o     = dec_early_reg & ~dec_home_reg;
  assign dec_at_home_o        = dec_at_home_reg;

  // Held state words; homing overrides a core write in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `ST_DEPTH; i++) st_mem_reg[i] <= homing_pkg::home_value(6'(i));
    end else begin
      if (st_we_i && st_wr_i.addr <= `ST_LAST) st_mem_reg[st_wr_i.addr] <= st_wr_i.data;
      for (int i = 0; i < `ST_DEPTH; i++) begin
        if (enc_home_now && 6'(i) < `ST_DEC_LSP) st_mem_reg[i] <= homing_pkg::home_value(6'(i));
        if (dec_home_now && 6'(i) >= `ST_DEC_LSP) st_mem_reg[i] <= homing_pkg::home_value(6'(i));
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence enc_homing_end;
    enc_plast && enc_pend_hom_reg;
  endsequence
  sequence dec_homing_end;
    dec_slast && dec_pend_hom_reg;
  endsequence

  chk_enc_home_cause: assert property (enc_core_home_o |-> $past(enc_plast) || $past(enc_force))
    else $error("encoder homed before its frame finished");
  chk_enc_dhf_out: assert property (enc_core_prm_valid_i && enc_subst
    |=> enc_prm_o.data == homing_pkg::dhf_value($past(enc_pidx))) else $error("encoder did not emit homing params");
  chk_enc_home_follows: assert property (enc_homing_end |=> enc_core_home_o && enc_at_home_o)
    else $error("encoder missed homing");
  chk_enc_repeat_home: assert property (enc_homing_end ##1 enc_core_prm_valid_i && enc_pend_hom_reg
    |=> enc_prm_o.data == homing_pkg::dhf_value($past(enc_pidx))) else $error("repeat homing frame not answered");
  chk_dec_home_cause: assert property (dec_core_home_o |-> $past(dec_slast) || $past(dec_force))
    else $error("decoder homed before speech out");
  chk_dec_ehf_out: assert property (dec_core_smp_valid_i && dec_subst
    |=> dec_smp_o.data == `ENC_HOME_SAMPLE) else $error("decoder did not emit homing speech");
  chk_dec_home_follows: assert property (dec_homing_end |=> dec_core_home_o)
    else $error("decoder missed homing");
  chk_dec_at_home: assert property (dec_core_home_o |-> dec_at_home_o)
    else $error("decoder not at home after homing");
  chk_early_home: assert property (dec_early_home_o |-> $past(dec_at_home_reg) && early_en_reg)
    else $error("early detect outside home state");
  chk_enc_home_vals: assert property (enc_core_home_o |-> st_mem_reg[0] == 16'h7530
    && st_mem_reg[19] == 16'h9A70) else $error("encoder spectral home values wrong");
  chk_hp_cleared: assert property (enc_core_home_o |-> st_mem_reg[20] == 16'h0000
    && st_mem_reg[25] == 16'h0000) else $error("pre-filter memory not cleared");
  chk_dec_home_vals: assert property (dec_core_home_o |-> st_mem_reg[36] == `AGC_HOME_GAIN
    && st_mem_reg[40] == `QUA_EN_HOME && st_mem_reg[26] == 16'h7530) else $error("decoder home values wrong");

endmodule
